// ==== hdl/home_node_map.svh ====
`ifndef HOME_NODE_MAP_SVH
`define HOME_NODE_MAP_SVH

// register offsets
`define HN_OFS_PRIMARY        16'h0900
`define HN_OFS_SECONDARY      16'h0908
`define HN_OFS_OVERRIDE       16'h0980
`define HN_OFS_CONFIG         16'h0a00

// primary capability field positions
`define HN_USAGE_MON_LSB      49
`define HN_SEC_GROUP_BIT      48
`define HN_SEC_PART_LSB       44
`define HN_NS_GROUP_BIT       43
`define HN_NS_PART_LSB        39
`define HN_QUEUE_LSB          32
`define HN_EXCL_LSB           24
`define HN_DATA_LAT_LSB       20
`define HN_TAG_LAT_LSB        16
`define HN_WAYS_LSB           8

// secondary capability field positions
`define HN_VEC_WIDTH_LSB      8
`define HN_CLUSTER_LSB        0

// override register layout
`define HN_OVR_WIDTH          7
`define HN_OVR_CONFIG_BIT     1

// reset values and partition code limit
`define HN_OVR_RESET          7'h00
`define HN_CONFIG_RESET       64'h0000_0000_0000_0000
`define HN_PART_CODE_MAX      4'h9
`endif

// ==== hdl/home_node_pkg.sv ====
package home_node_pkg;

    typedef enum logic [2:0] {
        phase_idle = 3'b001,
        phase_read = 3'b010,
        phase_deny = 3'b100
    } read_phase_type;

    typedef struct packed {
        read_phase_type phase;
        logic [63:0]    rd_data;
        logic [6:0]     override;
        logic [63:0]    config_word;
    } regs_state_type;

endpackage : home_node_pkg

// ==== hdl/secure_access_check.sv ====
`include "home_node_map.svh"

module secure_access_check (
    input  wire logic [15:0] addr,
    input  wire logic        secure,
    input  wire logic        config_override,
    output logic             hit_primary,
    output logic             hit_secondary,
    output logic             hit_override,
    output logic             hit_config,
    output logic             permitted
);
    logic mapped;

    assign hit_primary   = (addr == `HN_OFS_PRIMARY);
    assign hit_secondary = (addr == `HN_OFS_SECONDARY);
    assign hit_override  = (addr == `HN_OFS_OVERRIDE);
    assign hit_config    = (addr == `HN_OFS_CONFIG);
    assign mapped        = hit_primary | hit_secondary | hit_override | hit_config;

    // the override only widens the config register, never the rest
    assign permitted = mapped & (secure | (hit_config & config_override));

endmodule : secure_access_check

// ==== hdl/home_node_info_config_regs.sv ====
`include "home_node_map.svh"

module home_node_info_config_regs #(
    parameter logic [4:0] USAGE_MONITORS          = 5'h04,
    parameter logic       SECURE_TWO_GROUPS       = 1'b1,
    parameter logic [3:0] SECURE_PARTITION_CODE   = 4'h4,
    parameter logic       NONSECURE_TWO_GROUPS    = 1'b1,
    parameter logic [3:0] NONSECURE_PARTITION_CODE = 4'h6,
    parameter logic [6:0] ORDERING_QUEUE_ENTRIES  = 7'h20,
    parameter logic [7:0] EXCLUSIVE_MONITORS      = 8'h20,
    parameter logic [2:0] DATA_RAM_LATENCY        = 3'h2,
    parameter logic [2:0] TAG_RAM_LATENCY         = 3'h1,
    parameter logic [4:0] CACHE_WAYS              = 5'h10,
    parameter int         TOTAL_REQUESTERS        = 32,
    parameter int         CLUSTER_SIZE_PARAMETER  = 4,
    parameter int         ADDITIONAL_VECTOR_WIDTH = 0
) (
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic [15:0] addr,
    input  wire logic [63:0] wr_data,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    input  wire logic        secure,
    output logic      [63:0] rd_data,
    output logic             rd_denied,
    output logic      [63:0] config_control,
    output logic             config_nonsecure_open
);
    localparam int TRACKING_VECTOR_INT =
        TOTAL_REQUESTERS / CLUSTER_SIZE_PARAMETER + ADDITIONAL_VECTOR_WIDTH;
    localparam logic [7:0] TRACKING_VECTOR_BITS = 8'(TRACKING_VECTOR_INT);
    localparam logic [3:0] CLUSTER_FIELD = 4'(CLUSTER_SIZE_PARAMETER);

    home_node_pkg::regs_state_type state;
    home_node_pkg::regs_state_type next_state;

    logic [63:0] primary_word;
    logic [63:0] secondary_word;
    logic [63:0] override_word;
    logic        hit_primary;
    logic        hit_secondary;
    logic        hit_override;
    logic        hit_config;
    logic        permitted;

    secure_access_check u_secure_access_check (
        .addr            (addr),
        .secure          (secure),
        .config_override (state.override[`HN_OVR_CONFIG_BIT]),
        .hit_primary     (hit_primary),
        .hit_secondary   (hit_secondary),
        .hit_override    (hit_override),
        .hit_config      (hit_config),
        .permitted       (permitted)
    );

    // capability words are build constants; every unlisted bit stays zero
    always_comb begin
        primary_word = 64'h0;
        primary_word[`HN_USAGE_MON_LSB +: 5] = USAGE_MONITORS;
        primary_word[`HN_SEC_GROUP_BIT]    = SECURE_TWO_GROUPS;
        primary_word[`HN_SEC_PART_LSB +: 4] = SECURE_PARTITION_CODE;
        primary_word[`HN_NS_GROUP_BIT]     = NONSECURE_TWO_GROUPS;
        primary_word[`HN_NS_PART_LSB +: 4] = NONSECURE_PARTITION_CODE;
        primary_word[`HN_QUEUE_LSB +: 7]   = ORDERING_QUEUE_ENTRIES;
        primary_word[`HN_EXCL_LSB +: 8]    = EXCLUSIVE_MONITORS;
        primary_word[`HN_DATA_LAT_LSB +: 3] = DATA_RAM_LATENCY;
        primary_word[`HN_TAG_LAT_LSB +: 3] = TAG_RAM_LATENCY;
        primary_word[`HN_WAYS_LSB +: 5]    = CACHE_WAYS;
    end

    always_comb begin
        secondary_word = 64'h0;
        secondary_word[`HN_VEC_WIDTH_LSB +: 8] = TRACKING_VECTOR_BITS;
        secondary_word[`HN_CLUSTER_LSB +: 4]   = CLUSTER_FIELD;
    end

    assign override_word = {57'h0, state.override};

    always_comb begin
        next_state         = state;
        next_state.rd_data = 64'h0;
        next_state.phase   = home_node_pkg::phase_idle;
        if (rd_en) begin
            if (permitted) begin
                next_state.phase = home_node_pkg::phase_read;
                case (1'b1)
                    hit_primary:   next_state.rd_data = primary_word;
                    hit_secondary: next_state.rd_data = secondary_word;
                    hit_override:  next_state.rd_data = override_word;
                    hit_config:    next_state.rd_data = state.config_word;
                    default:       next_state.rd_data = 64'h0;
                endcase
            end else begin
                // refused or unmapped reads answer zero and flag the denial
                next_state.phase = home_node_pkg::phase_deny;
            end
        end
        // capability offsets simply have no write path
        if (wr_en && permitted) begin
            if (hit_override) begin
                next_state.override = wr_data[`HN_OVR_WIDTH-1:0];
            end
            if (hit_config) begin
                // late writes are not blocked: ordering against traffic is software's job
                next_state.config_word = wr_data;
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state.phase       <= home_node_pkg::phase_idle;
            state.rd_data     <= 64'h0;
            state.override    <= `HN_OVR_RESET;
            state.config_word <= `HN_CONFIG_RESET;
        end else begin
            state <= next_state;
        end
    end

    always_comb begin
        case (state.phase)
            home_node_pkg::phase_deny: rd_denied = 1'b1;
            home_node_pkg::phase_read: rd_denied = 1'b0;
            home_node_pkg::phase_idle: rd_denied = 1'b0;
            default:                   rd_denied = 1'b0;
        endcase
    end

    assign rd_data               = state.rd_data;
    assign config_control        = state.config_word;
    assign config_nonsecure_open = state.override[`HN_OVR_CONFIG_BIT];

    // checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    sequence primary_read;
        rd_en && secure && addr == `HN_OFS_PRIMARY;
    endsequence

    sequence secondary_read;
        rd_en && secure && addr == `HN_OFS_SECONDARY;
    endsequence

    sequence open_config;
        wr_en && secure && addr == `HN_OFS_OVERRIDE && wr_data[`HN_OVR_CONFIG_BIT];
    endsequence

    sequence nonsecure_config_write;
        wr_en && !secure && !rd_en && addr == `HN_OFS_CONFIG;
    endsequence

    sequence nonsecure_config_read;
        rd_en && !secure && !wr_en && addr == `HN_OFS_CONFIG;
    endsequence

    sequence config_write;
        wr_en && secure && !rd_en && addr == `HN_OFS_CONFIG;
    endsequence

    sequence override_write;
        wr_en && secure && !rd_en && addr == `HN_OFS_OVERRIDE;
    endsequence

    sequence config_read;
        rd_en && secure && !wr_en && addr == `HN_OFS_CONFIG;
    endsequence

    sequence override_read;
        rd_en && secure && !wr_en && addr == `HN_OFS_OVERRIDE;
    endsequence

    // anything outside the four offsets is refused, secure or not
    sequence unmapped_read;
        rd_en && addr != `HN_OFS_PRIMARY && addr != `HN_OFS_SECONDARY
              && addr != `HN_OFS_OVERRIDE && addr != `HN_OFS_CONFIG;
    endsequence

    a_usage_monitor_count: assert property (
        primary_read |=> rd_data[53:49] == USAGE_MONITORS && !rd_denied)
        else $error("usage monitor count field wrong");

    a_secure_group_flag: assert property (
        primary_read |=> rd_data[48] == SECURE_TWO_GROUPS)
        else $error("secure monitor group flag wrong");

    a_secure_partition_code: assert property (
        primary_read |=> rd_data[47:44] == SECURE_PARTITION_CODE
                         && rd_data[47:44] <= `HN_PART_CODE_MAX)
        else $error("secure partition code wrong or out of range");

    a_nonsecure_group_flag: assert property (
        primary_read |=> rd_data[43] == NONSECURE_TWO_GROUPS)
        else $error("nonsecure monitor group flag wrong");

    a_nonsecure_partition_code: assert property (
        primary_read |=> rd_data[42:39] == NONSECURE_PARTITION_CODE
                         && rd_data[42:39] <= `HN_PART_CODE_MAX)
        else $error("nonsecure partition code wrong or out of range");

    a_queue_depth_field: assert property (
        primary_read |=> rd_data[38:32] == ORDERING_QUEUE_ENTRIES)
        else $error("ordering queue entry field wrong");

    a_exclusive_count: assert property (
        primary_read |=> rd_data[31:24] == EXCLUSIVE_MONITORS)
        else $error("exclusive monitor count wrong");

    a_data_latency_field: assert property (
        primary_read |=> rd_data[22:20] == DATA_RAM_LATENCY)
        else $error("data RAM latency field wrong");

    a_tag_latency_field: assert property (
        primary_read |=> rd_data[18:16] == TAG_RAM_LATENCY)
        else $error("tag RAM latency field wrong");

    a_way_count_field: assert property (
        primary_read |=> rd_data[12:8] == CACHE_WAYS)
        else $error("cache way count wrong");

    a_vector_width_field: assert property (
        secondary_read |=> rd_data[15:8] == TRACKING_VECTOR_BITS && !rd_denied)
        else $error("tracking vector width field wrong");

    a_vector_width_sum: assert property (
        secondary_read |=> int'(rd_data[15:8]) ==
            (TOTAL_REQUESTERS / CLUSTER_SIZE_PARAMETER + ADDITIONAL_VECTOR_WIDTH) % 256)
        else $error("tracking vector width not requesters per cluster plus extra");

    a_cluster_size_field: assert property (
        secondary_read |=> rd_data[3:0] == CLUSTER_FIELD)
        else $error("cluster size field wrong");

    a_secure_only_read: assert property (
        (rd_en && !secure && !(addr == `HN_OFS_CONFIG && config_nonsecure_open))
        |=> rd_denied && rd_data == 64'h0)
        else $error("nonsecure read was not refused");

    a_secure_only_write: assert property (
        (wr_en && !secure && !(addr == `HN_OFS_CONFIG && config_nonsecure_open))
        |=> $stable(config_control) && $stable(state.override))
        else $error("nonsecure write changed a register");

    a_override_opens_config: assert property (
        open_config ##1 nonsecure_config_write ##1 nonsecure_config_read
        |=> !rd_denied && rd_data == $past(wr_data, 2))
        else $error("override did not open config to nonsecure access");

    a_capability_write_ignored: assert property (
        (wr_en && (addr == `HN_OFS_PRIMARY || addr == `HN_OFS_SECONDARY))
        |=> $stable(config_control) && $stable(state.override))
        else $error("write to capability register had an effect");

    a_reserved_bits_zero: assert property (
        primary_read |=> rd_data[63:54] == 10'h0 && rd_data[23] == 1'b0
                         && rd_data[19] == 1'b0 && rd_data[15:13] == 3'h0
                         && rd_data[7:0] == 8'h0)
        else $error("reserved primary bits not zero");

    a_reserved_secondary_zero: assert property (
        secondary_read |=> rd_data[63:16] == 48'h0 && rd_data[7:4] == 4'h0)
        else $error("reserved secondary bits not zero");

    a_read_data_one_cycle: assert property (
        !rd_en |=> rd_data == 64'h0 && !rd_denied)
        else $error("read data stood outside its answer cycle");

    a_config_write_lands: assert property (
        config_write |=> config_control == $past(wr_data))
        else $error("secure config write did not land");

    a_override_write_lands: assert property (
        override_write |=> config_nonsecure_open == $past(wr_data[`HN_OVR_CONFIG_BIT]))
        else $error("override bit did not take the written value");

    a_config_readback: assert property (
        config_read |=> rd_data == $past(config_control) && !rd_denied)
        else $error("config read did not return the stored word");

    // only bits 6:0 exist; the rest must read back as zero
    a_override_readback: assert property (
        override_read |=> rd_data[63:7] == 57'h0 && !rd_denied
                          && rd_data[`HN_OVR_CONFIG_BIT] == $past(config_nonsecure_open))
        else $error("override read did not return the stored bits");

    a_unmapped_denied: assert property (
        unmapped_read |=> rd_denied && rd_data == 64'h0)
        else $error("unmapped read was not refused");

    // stored words stand until an accepted write replaces them
    a_config_holds_idle: assert property (
        !wr_en |=> $stable(config_control) && $stable(config_nonsecure_open))
        else $error("stored register changed without a write");

    a_closed_config_refused: assert property (
        (wr_en && !secure && addr == `HN_OFS_CONFIG && !config_nonsecure_open)
        |=> $stable(config_control))
        else $error("nonsecure config write landed while closed");

    a_open_config_write: assert property (
        (wr_en && !secure && !rd_en && addr == `HN_OFS_CONFIG && config_nonsecure_open)
        |=> config_control == $past(wr_data))
        else $error("nonsecure config write refused while open");

    a_open_config_read: assert property (
        (rd_en && !secure && !wr_en && addr == `HN_OFS_CONFIG && config_nonsecure_open)
        |=> !rd_denied && rd_data == $past(config_control))
        else $error("nonsecure config read refused while open");

    // the override bit widens the config register only, never its neighbours
    a_open_keeps_others: assert property (
        (rd_en && !secure && addr != `HN_OFS_CONFIG && config_nonsecure_open)
        |=> rd_denied)
        else $error("override opened a register other than config");

    a_mapped_read_granted: assert property (
        (rd_en && secure && (addr == `HN_OFS_PRIMARY || addr == `HN_OFS_SECONDARY
                             || addr == `HN_OFS_OVERRIDE || addr == `HN_OFS_CONFIG))
        |=> !rd_denied)
        else $error("secure read of a mapped register was refused");

    a_denied_needs_read: assert property (
        rd_denied |-> $past(rd_en) && rd_data == 64'h0)
        else $error("denial flag without a read");

    a_phase_onehot: assert property (
        $onehot(state.phase))
        else $error("read phase left its one-hot codes");

    a_nonsecure_override_refused: assert property (
        (wr_en && !secure && addr == `HN_OFS_OVERRIDE) |=> $stable(config_nonsecure_open))
        else $error("nonsecure write reached the override register");

    // writes carry no answer, so the read lanes stay quiet after them
    a_write_no_answer: assert property (
        (wr_en && !rd_en) |=> rd_data == 64'h0 && !rd_denied)
        else $error("write produced a read answer");

    // after reset the config register is secure-only and nothing is pending
    a_reset_values: assert property (
        $rose(nrst) |-> config_control == 64'h0 && !config_nonsecure_open
                        && rd_data == 64'h0 && !rd_denied)
        else $error("register state wrong after reset");

endmodule : home_node_info_config_regs

// ==== dv/home_node_info_config_regs_bench.sv ====
`include "home_node_map.svh"

`define CHK(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("unexpected %s expected %h seen %h", what, exp, got); end end

module home_node_info_config_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;

    // odd field values so that a swapped or shifted field shows up
    localparam logic [4:0] usage    = 5'h13;
    localparam logic       sgrp     = 1'b0;
    localparam logic [3:0] spart    = 4'h9;
    localparam logic       ngrp     = 1'b1;
    localparam logic [3:0] npart    = 4'h5;
    localparam logic [6:0] queue    = 7'h5b;
    localparam logic [7:0] excl     = 8'ha7;
    localparam logic [2:0] dlat     = 3'h5;
    localparam logic [2:0] tlat     = 3'h3;
    localparam logic [4:0] ways     = 5'h1c;
    localparam int         total_rq = 64;
    localparam int         cluster  = 8;
    localparam int         extra    = 3;
    localparam logic [63:0] primary = {10'h000, usage, sgrp, spart, ngrp, npart, queue, excl,
                                       1'b0, dlat, 1'b0, tlat, 3'h0, ways, 8'h00};
    localparam logic [63:0] secondary = {48'h0, 8'h0b, 4'h0, 4'h8};

    logic        mclk = 1'b0;
    logic        nrst = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [63:0] wr_data = 64'h0;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic        secure = 1'b0;
    logic [63:0] rd_data;
    logic        rd_denied;
    logic [63:0] config_control;
    logic        config_nonsecure_open;
    int          error_cnt = 0;
    int          num_checks = 0;

    always #20 mclk = ~mclk;

    home_node_info_config_regs #(
        .USAGE_MONITORS(usage), .SECURE_TWO_GROUPS(sgrp), .SECURE_PARTITION_CODE(spart),
        .NONSECURE_TWO_GROUPS(ngrp), .NONSECURE_PARTITION_CODE(npart),
        .ORDERING_QUEUE_ENTRIES(queue), .EXCLUSIVE_MONITORS(excl),
        .DATA_RAM_LATENCY(dlat), .TAG_RAM_LATENCY(tlat), .CACHE_WAYS(ways),
        .TOTAL_REQUESTERS(total_rq), .CLUSTER_SIZE_PARAMETER(cluster),
        .ADDITIONAL_VECTOR_WIDTH(extra)
    ) u_home_node_info_config_regs (
        .mclk(mclk), .nrst(nrst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .secure(secure), .rd_data(rd_data), .rd_denied(rd_denied),
        .config_control(config_control), .config_nonsecure_open(config_nonsecure_open)
    );

    task automatic wr(input logic [15:0] a, input logic [63:0] d, input logic s);
        @(posedge mclk);
        addr <= a;
        wr_data <= d;
        secure <= s;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
        @(negedge mclk);
    endtask : wr

    // read data stand only in the cycle after the strobe, so look there
    task automatic rd(input logic [15:0] a, input logic s, input logic [63:0] exp,
                      input logic den);
        @(posedge mclk);
        addr <= a;
        secure <= s;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        @(negedge mclk);
        `CHK("read data", exp, rd_data)
        `CHK("read denied", den, rd_denied)
    endtask : rd

    task automatic check_reset_state;
        `CHK("config after reset", 64'h0, config_control)
        `CHK("open after reset", 1'b0, config_nonsecure_open)
        `CHK("answer after reset", 64'h0, rd_data)
        `CHK("denial after reset", 1'b0, rd_denied)
        rd(`HN_OFS_CONFIG, 1'b1, 64'h0, 1'b0);
        rd(`HN_OFS_OVERRIDE, 1'b1, 64'h0, 1'b0);
    endtask : check_reset_state

    task automatic check_capability;
        rd(`HN_OFS_PRIMARY, 1'b1, primary, 1'b0);
        @(negedge mclk);
        `CHK("data after answer", 64'h0, rd_data)
        rd(`HN_OFS_SECONDARY, 1'b1, secondary, 1'b0);
    endtask : check_capability

    task automatic check_read_only;
        wr(`HN_OFS_PRIMARY, 64'hffff_ffff_ffff_ffff, 1'b1);
        wr(`HN_OFS_SECONDARY, 64'hffff_ffff_ffff_ffff, 1'b1);
        rd(`HN_OFS_PRIMARY, 1'b1, primary, 1'b0);
        rd(`HN_OFS_SECONDARY, 1'b1, secondary, 1'b0);
        `CHK("config untouched", 64'h0, config_control)
    endtask : check_read_only

    task automatic check_secure_only;
        logic [15:0] offs [4];
        offs = '{`HN_OFS_PRIMARY, `HN_OFS_SECONDARY, `HN_OFS_OVERRIDE, `HN_OFS_CONFIG};
        foreach (offs[i]) rd(offs[i], 1'b0, 64'h0, 1'b1);
        wr(`HN_OFS_CONFIG, 64'h1234_5678_9abc_def0, 1'b0);
        `CHK("nonsecure config write", 64'h0, config_control)
        wr(`HN_OFS_OVERRIDE, 64'h2, 1'b0);
        `CHK("nonsecure override write", 1'b0, config_nonsecure_open)
        rd(16'h0910, 1'b1, 64'h0, 1'b1);
    endtask : check_secure_only

    task automatic check_config_rw;
        wr(`HN_OFS_CONFIG, 64'ha5c3_0f1e_8421_7bde, 1'b1);
        `CHK("config written", 64'ha5c3_0f1e_8421_7bde, config_control)
        rd(`HN_OFS_CONFIG, 1'b1, 64'ha5c3_0f1e_8421_7bde, 1'b0);
    endtask : check_config_rw

    // configuration is finished here before any other traffic would start
    task automatic check_override;
        wr(`HN_OFS_OVERRIDE, 64'hffff_ffff_ffff_ff82, 1'b1);
        `CHK("override open", 1'b1, config_nonsecure_open)
        rd(`HN_OFS_OVERRIDE, 1'b1, 64'h0000_0000_0000_0002, 1'b0);
        wr(`HN_OFS_CONFIG, 64'h0f0f_0000_ffff_0001, 1'b0);
        `CHK("nonsecure config accepted", 64'h0f0f_0000_ffff_0001, config_control)
        rd(`HN_OFS_CONFIG, 1'b0, 64'h0f0f_0000_ffff_0001, 1'b0);
        rd(`HN_OFS_PRIMARY, 1'b0, 64'h0, 1'b1);
        wr(`HN_OFS_OVERRIDE, 64'h0, 1'b1);
        `CHK("override closed", 1'b0, config_nonsecure_open)
        wr(`HN_OFS_CONFIG, 64'h0, 1'b0);
        `CHK("closed config kept", 64'h0f0f_0000_ffff_0001, config_control)
    endtask : check_override

    // strobes back to back: open the override, then write and read config as nonsecure
    task automatic check_back_to_back;
        @(posedge mclk);
        addr <= `HN_OFS_OVERRIDE;
        wr_data <= 64'h0000_0000_0000_0002;
        secure <= 1'b1;
        wr_en <= 1'b1;
        @(posedge mclk);
        addr <= `HN_OFS_CONFIG;
        wr_data <= 64'h3c3c_5a5a_0000_ffff;
        secure <= 1'b0;
        @(posedge mclk);
        wr_en <= 1'b0;
        rd_en <= 1'b1;
        @(posedge mclk);
        addr <= `HN_OFS_PRIMARY;
        secure <= 1'b1;
        @(negedge mclk);
        `CHK("back to back config", 64'h3c3c_5a5a_0000_ffff, rd_data)
        `CHK("back to back denied", 1'b0, rd_denied)
        @(posedge mclk);
        rd_en <= 1'b0;
        @(negedge mclk);
        `CHK("back to back primary", primary, rd_data)
        `CHK("back to back stored", 64'h3c3c_5a5a_0000_ffff, config_control)
    endtask : check_back_to_back

    // reset in mid-run while both stored registers hold nonzero values
    task automatic check_mid_reset;
        @(posedge mclk);
        nrst <= 1'b0;
        @(negedge mclk);
        `CHK("config in reset", 64'h0, config_control)
        `CHK("open in reset", 1'b0, config_nonsecure_open)
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        @(negedge mclk);
        check_reset_state();
    endtask : check_mid_reset

    task automatic conclude;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    initial begin
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        @(negedge mclk);
        check_reset_state();
        check_capability();
        check_read_only();
        check_secure_only();
        check_config_rw();
        check_override();
        check_back_to_back();
        check_mid_reset();
        conclude();
    end

    // whole run needs about 73 cycles; a hang stops well after that
    initial begin
        repeat (2000) @(posedge mclk);
        error_cnt++;
        conclude();
    end

endmodule : home_node_info_config_regs_bench
